/* logic/rtc_cal_defines.vh */
// Constants for the clock/calendar calibration and register block.
// Assumes inclusion by bare name from logic/ and a 32-bit AHB-Lite bus.
`ifndef RTC_CAL_DEFINES_VH
`define RTC_CAL_DEFINES_VH
// ****************************************
// Register indices, byte address = 4 x index
// ****************************************
`define IDX_PAD_CONFIG 12'h2fc
`define IDX_ALARM_VALUE 12'h620
`define IDX_ALARM_CONFIG 12'h622
`define IDX_TIME_VALUE 12'h624
`define IDX_CLOCK_CONFIG 12'h626
`define IDX_EVENT_STATUS 12'h630
`define IDX_EVENT_CLEAR 12'h631
`define IDX_EVENT_ENABLE 12'h632
// ****************************************
// Field positions
// ****************************************
`define CFG_ENABLE_BIT 15
`define CFG_UNLOCK_BIT 13
`define CFG_WINDOW_BIT 12
`define CFG_HALF_BIT 11
`define CFG_OUT_EN_BIT 10
`define PAD_SELECT_BIT 1
`define EVT_ALARM 0
`define EVT_SECOND 1
`define EVT_TRIM 2
`define EVT_WIDTH 3
// ****************************************
// Reset values and timing counts
// ****************************************
`define RST_REG16 16'h0000
`define OSC_PER_SECOND 32768
`define TRIM_POINT 512
`define STEP_CYCLES 4
`define WINDOW_EDGES 32
`define OSC_PER_MINUTE 1966080
`endif

/* logic/rtc_cal_block.v */
// Calibration prescaler, clock output and register map of a BCD clock/calendar.
// Assumes a 32.768 kHz oscillator pin, an outside counter chain and alarm compare on hclk.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cal_defines.vh"

// What this block does
// - Trim is the signed 8-bit low byte of the config/calibration register.
// - Positive trim speeds the clock, negative slows it, zero leaves it alone.
// - Each step moves four oscillator cycles, applied once per minute.
// - Trim is applied at the 512th oscillator edge after seconds wrap 59 to 00.
// - Trim field is sampled at that point and scaled by four per step.
// - The 1 Hz seconds clock can be driven onto the clock output pin.
// - Timekeeping keeps running from the oscillator during Sleep.
// - An enabled alarm event during Sleep wakes the device.
// - Idle mode has no effect on the clock/calendar.
// - Alarm window is one address selecting byte pairs by a two-bit pointer.
// - Unused bits read zero, except alarm config keeps all 16 written bits; value windows undefined at reset, others reset zero.
// - Select 0 toggles the pin on alarm events, select 1 gives seconds clock.
// - Rollover window flag set 32 edges before prescaler rollover, cleared after.
module rtc_cal_block #(
  parameter PRESCALE_BITS = 15
) (
  // Bus clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Oscillator pin and counter chain
  input wire osc_in,
  input wire seconds_wrap,
  input wire alarm_event,
  output reg seconds_tick_q,
  output reg prescaler_reset_q,
  // Power modes
  input wire sleep_mode,
  input wire idle_mode,
  output reg wake_q,
  // Clock output pin
  output reg clk_pin_o_q,
  output reg clk_pin_oe_q,
  // Interrupt
  output reg irq_q
);

  // ****************************************
  // Oscillator edge detection
  // ****************************************
  reg osc_meta_q;
  reg osc_sync_q;
  reg osc_last_q;
  wire osc_tick = osc_sync_q & ~osc_last_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_last_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_in;
      osc_sync_q <= osc_meta_q;
      osc_last_q <= osc_sync_q;
    end
  end

  // ****************************************
  // Derived prescaler constants
  // ****************************************
  // Sized to the prescaler, so a shortened test prescaler keeps every point
  localparam [PRESCALE_BITS-1:0] PRESCALE_TOP = {PRESCALE_BITS{1'b1}};
  localparam [31:0] WINDOW_SPAN_W = `WINDOW_EDGES - 1;
  localparam [PRESCALE_BITS-1:0] WINDOW_SPAN = WINDOW_SPAN_W[PRESCALE_BITS-1:0];
  localparam [PRESCALE_BITS-1:0] WINDOW_START = PRESCALE_TOP - WINDOW_SPAN;
  // Trim lands on the tick that leaves this count, replacing the 512th edge
  localparam [31:0] TRIM_LAST_W = `TRIM_POINT - 1;
  localparam [PRESCALE_BITS-1:0] TRIM_LAST = TRIM_LAST_W[PRESCALE_BITS-1:0];

  // ****************************************
  // Registers
  // ****************************************
  reg [15:0] clock_config_q;
  reg [15:0] alarm_config_q;
  reg [15:0] pad_config_q;
  reg [`EVT_WIDTH-1:0] status_q;
  reg [`EVT_WIDTH-1:0] enable_q;
  // No reset: contents undefined after reset
  reg [15:0] time_mem [0:3];
  reg [15:0] alarm_mem [0:2];

  reg [PRESCALE_BITS-1:0] prescale_q;
  reg trim_pending_q;
  reg [`EVT_WIDTH-1:0] event_d;

  wire [7:0] trim = clock_config_q[7:0];
  wire [1:0] time_ptr = clock_config_q[9:8];
  wire [1:0] alarm_ptr = alarm_config_q[9:8];
  wire window_flag = (prescale_q >= WINDOW_START);
  wire half_flag = prescale_q[PRESCALE_BITS-1];
  wire prescale_last = (prescale_q == PRESCALE_TOP);

  // ****************************************
  // Bus address phase capture
  // ****************************************
  // Zero wait states: a write lands at the end of its data phase
  reg wr_pend_q;
  reg [11:0] wr_idx_q;
  wire take = hsel & htrans[1] & hready;
  wire addr_ok = (haddr[31:14] == 18'h0) & (haddr[1:0] == 2'b00);
  wire [11:0] idx = haddr[13:2];
  wire rd_take = take & ~hwrite & addr_ok;
  wire wr_fire = wr_pend_q;
  wire time_wr = wr_fire & (wr_idx_q == `IDX_TIME_VALUE) & clock_config_q[`CFG_UNLOCK_BIT];
  wire alarm_wr = wr_fire & (wr_idx_q == `IDX_ALARM_VALUE);
  wire time_rd = rd_take & (idx == `IDX_TIME_VALUE);
  wire alarm_rd = rd_take & (idx == `IDX_ALARM_VALUE);

  reg [31:0] rdata_d;

  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `IDX_PAD_CONFIG: rdata_d[1:0] = pad_config_q[1:0];
      `IDX_ALARM_VALUE: rdata_d[15:0] = (alarm_ptr == 2'b11) ? 16'h0000 : alarm_mem[alarm_ptr];
      `IDX_ALARM_CONFIG: rdata_d[15:0] = alarm_config_q;
      `IDX_TIME_VALUE: rdata_d[15:0] = time_mem[time_ptr];
      `IDX_CLOCK_CONFIG:
      begin
        rdata_d[15:0] = clock_config_q & 16'hb7ff;
        rdata_d[`CFG_WINDOW_BIT] = window_flag;
        rdata_d[`CFG_HALF_BIT] = half_flag;
      end
      `IDX_EVENT_STATUS: rdata_d[`EVT_WIDTH-1:0] = status_q;
      `IDX_EVENT_CLEAR: rdata_d = 32'h0000_0000;
      `IDX_EVENT_ENABLE: rdata_d[`EVT_WIDTH-1:0] = enable_q;
      default: rdata_d = 32'h0000_0000;
    endcase
    if (!addr_ok)
      rdata_d = 32'h0000_0000;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 12'h000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= take & hwrite & addr_ok;
      if (take)
        wr_idx_q <= idx;
      if (rd_take)
        hrdata <= rdata_d;
    end
  end

  // ****************************************
  // Value windows
  // ****************************************
  always @(posedge hclk)
  begin
    if (time_wr)
      time_mem[time_ptr] <= hwdata[15:0];
    // Pointer 3 of the alarm window has no storage
    if (alarm_wr && alarm_ptr != 2'b11)
      alarm_mem[alarm_ptr] <= hwdata[15:0];
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clock_config_q <= `RST_REG16;
      alarm_config_q <= `RST_REG16;
      pad_config_q <= `RST_REG16;
      enable_q <= {`EVT_WIDTH{1'b0}};
    end
    else
    begin
      if (wr_fire && wr_idx_q == `IDX_CLOCK_CONFIG)
      begin
        // Enable bit only moves while unlocked; unlock sequencing lives elsewhere
        if (clock_config_q[`CFG_UNLOCK_BIT])
          clock_config_q[`CFG_ENABLE_BIT] <= hwdata[`CFG_ENABLE_BIT];
        clock_config_q[`CFG_UNLOCK_BIT] <= hwdata[`CFG_UNLOCK_BIT];
        clock_config_q[`CFG_OUT_EN_BIT] <= hwdata[`CFG_OUT_EN_BIT];
        clock_config_q[9:0] <= hwdata[9:0];
      end
      else if ((time_rd || (wr_fire && wr_idx_q == `IDX_TIME_VALUE)) && time_ptr != 2'b00)
        clock_config_q[9:8] <= time_ptr - 2'b01;
      if (wr_fire && wr_idx_q == `IDX_ALARM_CONFIG)
        alarm_config_q <= hwdata[15:0];
      else if ((alarm_rd || alarm_wr) && alarm_ptr != 2'b00)
        alarm_config_q[9:8] <= alarm_ptr - 2'b01;
      if (wr_fire && wr_idx_q == `IDX_PAD_CONFIG)
        pad_config_q[1:0] <= hwdata[1:0];
      if (wr_fire && wr_idx_q == `IDX_EVENT_ENABLE)
        enable_q <= hwdata[`EVT_WIDTH-1:0];
    end
  end

  // ****************************************
  // Prescaler and calibration
  // ****************************************
  // Sign-extended trim times four; 512 + range stays inside one second
  // Widened to a word first, so the cut to the prescaler width is on purpose
  wire [31:0] trim_word = {{22{trim[7]}}, trim, 2'b00};
  wire [PRESCALE_BITS-1:0] trim_cycles = trim_word[PRESCALE_BITS-1:0];
  wire at_trim_point = trim_pending_q & osc_tick & (prescale_q == TRIM_LAST);
  wire time_sec_written = time_wr & (time_ptr == 2'b00);
  wire running = clock_config_q[`CFG_ENABLE_BIT];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale_q <= {PRESCALE_BITS{1'b0}};
      trim_pending_q <= 1'b0;
      seconds_tick_q <= 1'b0;
      prescaler_reset_q <= 1'b0;
    end
    else
    begin
      // Runs on oscillator ticks only; sleep and idle are not looked at
      seconds_tick_q <= running & osc_tick & prescale_last;
      prescaler_reset_q <= time_sec_written;
      // Armed by the wrap and used once; a later wrap arms it again
      if (seconds_wrap)
        trim_pending_q <= 1'b1;
      else if (at_trim_point)
        trim_pending_q <= 1'b0;
      if (time_sec_written)
        prescale_q <= {PRESCALE_BITS{1'b0}};
      else if (running && osc_tick)
      begin
        if (at_trim_point)
          prescale_q <= prescale_q + 1'b1 + trim_cycles;
        else
          prescale_q <= prescale_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Events, interrupt, wake and clock pin
  // ****************************************
  always @*
  begin
    event_d = {`EVT_WIDTH{1'b0}};
    event_d[`EVT_ALARM] = alarm_event;
    event_d[`EVT_SECOND] = seconds_tick_q;
    event_d[`EVT_TRIM] = at_trim_point & running;
  end

  wire [`EVT_WIDTH-1:0] clear_bits =
    (wr_fire && wr_idx_q == `IDX_EVENT_CLEAR) ? hwdata[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= {`EVT_WIDTH{1'b0}};
    end
    else
    begin
      // Set wins over a clear in the same cycle
      status_q <= (status_q & ~clear_bits) | event_d;
    end
  end

  // ****************************************
  // Interrupt and wake
  // ****************************************
  // Both follow the status one cycle late, so they never glitch on a clear
  // Only the alarm wakes; the other events just interrupt
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_q & enable_q);
      wake_q <= sleep_mode & status_q[`EVT_ALARM] & enable_q[`EVT_ALARM];
    end
  end

  // ****************************************
  // Clock output pin
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_pin_o_q <= 1'b0;
      clk_pin_oe_q <= 1'b0;
    end
    else
    begin
      clk_pin_oe_q <= clock_config_q[`CFG_OUT_EN_BIT];
      // Seconds clock is high in the first half of each second
      if (pad_config_q[`PAD_SELECT_BIT])
        clk_pin_o_q <= ~half_flag;
      else if (alarm_event)
        clk_pin_o_q <= ~clk_pin_o_q;
    end
  end

  // Idle carries no behaviour: the block runs the same in Idle
  wire unused_ok = idle_mode | (|hsize);

endmodule // rtc_cal_block
`default_nettype wire

/* tb/rtc_cal_props.sv */
// Checker for the calibration block's ports.
// Assumes binding to rtc_cal_block with one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rtc_cal_props #(
  parameter PRESCALE_BITS = 15
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Block outputs and sleep mode input
  input wire seconds_tick_q,
  input wire prescaler_reset_q,
  input wire sleep_mode,
  input wire wake_q,
  input wire irq_q
);
  // ****
  // Properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_taken = hsel & htrans[1] & hready & !hwrite;
  a_zero_wait: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_hold_rdata: assert property (!$past(rd_taken) |-> $stable(hrdata))
    else $error("read data moved");
  a_tick_single: assert property (seconds_tick_q |=> !seconds_tick_q [*8])
    else $error("seconds tick too close");
  a_reset_pulse: assert property (prescaler_reset_q |=> !prescaler_reset_q)
    else $error("prescaler reset too long");
  a_wake_sleep: assert property (wake_q |-> $past(sleep_mode))
    else $error("wake outside sleep");
  a_wake_irq: assert property (wake_q |-> irq_q)
    else $error("wake without interrupt");
  c_tick: cover property (seconds_tick_q);
  c_wake: cover property (wake_q);
  c_prst: cover property (prescaler_reset_q);
endmodule // rtc_cal_props
bind rtc_cal_block rtc_cal_props #(.PRESCALE_BITS(PRESCALE_BITS)) i_props (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .seconds_tick_q, .prescaler_reset_q, .sleep_mode, .wake_q,
  .irq_q);
`default_nettype wire

/* tb/osc_model.sv */
// Free-running crystal model for the oscillator pin.
// Assumes a 40 MHz bench clock: six bench cycles per period.
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
  parameter HALF_NS = 75
) (
  // Oscillator pin
  output logic osc
);
  initial
  begin
    osc = 1'b0;
    #7;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule // osc_model
`default_nettype wire

/* tb/tb_rtc_calibration_prescaler.sv */
// Bench for the calibration prescaler and register map.
// Assumes logic/ on the include path and the oscillator model.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cal_defines.vh"
module tb_rtc_calibration_prescaler;
  // Short prescaler keeps one second at 6144 cycles
  localparam int PB = 10;
  localparam logic [31:0] A_PAD = 4 * `IDX_PAD_CONFIG;
  localparam logic [31:0] A_ALV = 4 * `IDX_ALARM_VALUE;
  localparam logic [31:0] A_ALC = 4 * `IDX_ALARM_CONFIG;
  localparam logic [31:0] A_TIM = 4 * `IDX_TIME_VALUE;
  localparam logic [31:0] A_CFG = 4 * `IDX_CLOCK_CONFIG;
  localparam logic [31:0] A_ST = 4 * `IDX_EVENT_STATUS;
  localparam logic [31:0] A_CLR = 4 * `IDX_EVENT_CLEAR;
  localparam logic [31:0] A_EN = 4 * `IDX_EVENT_ENABLE;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, seconds_wrap = 1'b0, alarm_event = 1'b0;
  logic sleep_mode = 1'b0, idle_mode = 1'b0, rdy_s, osc_in, hreadyout, hresp, seconds_tick_q;
  logic prescaler_reset_q, wake_q, clk_pin_o_q, clk_pin_oe_q, irq_q, p0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s, v;
  logic [31:0] regs[6] = '{A_PAD, A_ALC, A_CFG, A_ST, A_EN, 32'h3ffc};
  logic [31:0] q[$] = '{32'h1111, 32'h2222, 32'h3333};
  int errors = 0, comparisons = 0, cyc = 0, last = 0, gap = 0, ticks = 0, seed = 8189, t, prst = 0;
  int trims[7] = '{0, 1, -1, 127, -128, 0, 0};
  always #12.5 hclk = ~hclk;
  osc_model i_osc (.osc(osc_in));
  rtc_cal_block #(.PRESCALE_BITS(PB)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .osc_in, .seconds_wrap, .alarm_event,
    .seconds_tick_q, .prescaler_reset_q, .sleep_mode, .idle_mode, .wake_q, .clk_pin_o_q, .clk_pin_oe_q, .irq_q);
  // ****
  // Tasks and monitor
  // ****
  // Sampled mid-cycle so the edge's updates never race the bench
  always @(negedge hclk)
  begin
    rdy_s = hreadyout;
    rd_s = hrdata;
    cyc++;
    if (prescaler_reset_q === 1'b1)
      prst++;
    if (seconds_tick_q === 1'b1)
    begin
      gap = cyc - last;
      last = cyc;
      ticks++;
    end
  end
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wait_for(input int lim, input logic tk);
    int n;
    n = ticks;
    for (int k = 0; tk ? ticks == n : rdy_s !== 1'b1; k++)
    begin
      @(posedge hclk);
      if (k > lim)
      begin
        errors++;
        end_of_test;
      end
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    wait_for(50, 1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_for(50, 1'b0);
    r = rd_s;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (regs[i])
    begin
      bus(1'b0, regs[i], 32'h0, v);
      check("reset value", 32'h0, v);
    end
    bus(1'b1, A_PAD, 32'hffff, v);
    bus(1'b0, A_PAD, 32'h0, v);
    check("pad_config", 32'h3, v);
    bus(1'b1, A_ALC, 32'h0200, v);
    foreach (q[i]) bus(1'b1, A_ALV, q[i], v);
    bus(1'b0, A_ALC, 32'h0, v);
    check("alarm_pointer", 32'h0, v);
    bus(1'b1, A_ALC, 32'h0200, v);
    foreach (q[i])
    begin
      bus(1'b0, A_ALV, 32'h0, v);
      check("alarm window", q[i], v);
    end
    bus(1'b1, A_PAD, 32'h0, v);
    bus(1'b1, A_EN, 32'h1, v);
    p0 = clk_pin_o_q;
    sleep_mode <= 1'b1;
    alarm_event <= 1'b1;
    @(posedge hclk);
    alarm_event <= 1'b0;
    repeat (3) @(posedge hclk);
    check("irq_q", 32'h1, {31'h0, irq_q});
    check("wake_q", 32'h1, {31'h0, wake_q});
    check("clk_pin_o_q", {31'h0, ~p0}, {31'h0, clk_pin_o_q});
    bus(1'b1, A_EN, 32'h0, v);
    repeat (3) @(posedge hclk);
    check("masked irq_q", 32'h0, {31'h0, irq_q});
    bus(1'b1, A_CLR, 32'h1, v);
    bus(1'b0, A_ST, 32'h0, v);
    check("cleared status", 32'h0, v);
    bus(1'b1, A_CFG, 32'h2400, v);
    bus(1'b1, A_TIM, 32'h0, v);
    check("clk_pin_oe_q", 32'h1, {31'h0, clk_pin_oe_q});
    bus(1'b1, A_PAD, 32'h2, v);
    check("prescaler_reset_q", 32'h1, prst);
    bus(1'b1, A_CFG, 32'ha400, v);
    wait_for(12000, 1'b1);
    repeat (1000) @(posedge hclk);
    bus(1'b0, A_CFG, 32'h0, v);
    check("first half", 32'ha400, v);
    check("pin first half", 32'h1, {31'h0, clk_pin_o_q});
    repeat (3000) @(posedge hclk);
    bus(1'b0, A_CFG, 32'h0, v);
    check("second half", 32'hac00, v & ~32'h1000);
    check("pin second half", 32'h0, {31'h0, clk_pin_o_q});
    repeat (2000) @(posedge hclk);
    bus(1'b0, A_CFG, 32'h0, v);
    check("rollover window", 32'h1000, v & 32'h1000);
    wait_for(12000, 1'b1);
    check("plain second", (1 << PB) * 6, gap);
    foreach (trims[i])
    begin
      t = (i == 5) ? (2 * 60) / 4 : (i > 5) ? $random(seed) % 128 : trims[i];
      sleep_mode <= i[0];
      idle_mode <= i[1];
      bus(1'b1, A_CFG, 32'ha400 | (t & 32'hff), v);
      seconds_wrap <= 1'b1;
      @(posedge hclk);
      seconds_wrap <= 1'b0;
      wait_for(12000, 1'b1);
      check("trimmed second", ((1 << PB) - 4 * t) * 6, gap);
    end
    bus(1'b0, A_ST, 32'h0, v);
    check("trim status", 32'h4, v & 32'h4);
    end_of_test;
  end
endmodule // tb_rtc_calibration_prescaler
`default_nettype wire
